// file: verilog/cec_consts.svh
// Function
// - Frame is start bit, header, optional blocks
// - Block: eight bits MSB first, END_OF_MESSAGE_BIT, ACK
// - END_OF_MESSAGE_BIT only last block; ignore later blocks
// - END_OF_MESSAGE_BIT in header alone acts as ping
// - Initiator releases ACK; follower pulls low
// - Header: source then destination; 0xF broadcast
// - Start bit needs valid low and total
// - Falling edge ends bit; line high after last
// - Wait signal-free time: 7, 5 or 3 bits
// - Lose arbitration seeing low while released in source bits
// - Bad data-bit low duration flags bit timing error; bad start bit drops silently
// - Bad data-bit fall-to-fall interval flags period error; bad start bit drops silently
// - Both errors report only timing error
// - Either error drives 3.6 ms error bit
// - No ack, refusal, unexpected low: message lost
// - Retransmit lost message up to five times
// - Own address is header upper nibble
// - Whole messages, bytes exchanged one at a time
// - 14-bit prescaler gives 50 us quantum
// - Prescaler restarts at every bit start
// - Two-of-three majority vote on received line
// - Ignore rebounds until next whole quantum window
// - Drive only low or released, open drain
// - Falling edge captures total then restarts timer
// - Classify low duration: one, zero, start
// - Accept total durations for data and start
`ifndef CEC_CONSTS_SVH
`define CEC_CONSTS_SVH

`define CEC_QUANTUM_US 50
`define CEC_LEAST_Q(us) (10'(((us) + `CEC_QUANTUM_US - 1) / `CEC_QUANTUM_US))
`define CEC_MOST_Q(us) (10'((us) / `CEC_QUANTUM_US))

`define CEC_ONE_LOW_MIN_US 400
`define CEC_ONE_LOW_MAX_US 800
`define CEC_ZERO_LOW_MIN_US 1300
`define CEC_ZERO_LOW_MAX_US 1700
`define CEC_START_LOW_MIN_US 3500
`define CEC_START_LOW_MAX_US 3900
`define CEC_DATA_TOT_MIN_US 2050
`define CEC_DATA_TOT_MAX_US 2750
`define CEC_START_TOT_MIN_US 4300
`define CEC_START_TOT_MAX_US 4700

`define CEC_TX_START_LOW_US 3700
`define CEC_TX_START_TOT_US 4500
`define CEC_TX_ZERO_LOW_US 1500
`define CEC_TX_ONE_LOW_US 600
`define CEC_NOM_BIT_US 2400
`define CEC_ERR_LOW_US 3600

`define CEC_SFT_LAST_BITS 7
`define CEC_SFT_NEW_BITS 5
`define CEC_SFT_RETRY_BITS 3

`define CEC_MAX_RETRY 3'h5
`define CEC_BCAST_ADDR 4'hf
`define CEC_SRC_LAST_IDX 4'h3
`define CEC_DST_LAST_IDX 4'h7
`define CEC_EOM_IDX 4'h8
`define CEC_ACK_IDX 4'h9
`define CEC_REBOUND_TICKS 2'h2
`define CEC_TIMER_MAX 10'h3ff

`endif

// file: verilog/cec_pkg.sv
package cec_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_ERR} cec_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       end_of_message_bit;
  } cec_byte_t;

  typedef struct packed {
    logic bit_timing_error;
    logic bit_period_error;
    logic arb_lost;
    logic tx_done;
    logic tx_retry;
    logic tx_fail;
  } cec_evt_t;

  typedef struct packed {
    logic [1:0] sync;
    logic [1:0] smp;
    logic       lvl;
    logic [1:0] lock;
    logic       rise;
    logic       fall;
  } cec_filt_state_t;

  typedef struct packed {
    logic [13:0] cnt;
    logic        tick;
  } cec_prescale_value_state_t;

  typedef struct packed {
    cec_state_t st;
    logic [9:0] t;
    logic [9:0] low_len;
    logic       drv;
    logic       tx_act;
    logic       start_ph;
    logic [3:0] idx;
    logic       first;
    logic [7:0] sh;
    logic       end_of_message_bit;
    logic       addr_me;
    logic       bcast;
    logic [7:0] tx_sh;
    logic       tx_eom;
    logic       tx_bit;
    cec_byte_t  tx_buf;
    logic       tx_full;
    logic       tx_pend;
    logic [2:0] retry;
    logic       last_init;
    cec_byte_t  rx;
    logic       rx_valid;
    cec_evt_t   evt;
  } cec_ctrl_state_t;

endpackage

// file: verilog/cec_prescaler.sv
`include "cec_consts.svh"

module cec_prescaler (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Control
  input  wire logic [13:0] i_prescale_value,
  input  wire logic        i_restart,
  // Quantum pulse
  output logic             o_tick
);

  cec_pkg::cec_prescale_value_state_t s_q;
  cec_pkg::cec_prescale_value_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (i_restart) begin
      s_d.cnt = 14'h0;
    end else if (s_q.cnt >= i_prescale_value) begin
      s_d.cnt = 14'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 14'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

endmodule

// file: verilog/cec_rx_filter.sv
`include "cec_consts.svh"

module cec_rx_filter (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Raw line and quantum
  input  wire logic i_line,
  input  wire logic i_tick,
  // Filtered line
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  cec_pkg::cec_filt_state_t s_q;
  cec_pkg::cec_filt_state_t s_d;
  logic                     vote;

  always_comb begin
    s_d = s_q;
    s_d.rise = 1'b0;
    s_d.fall = 1'b0;
    s_d.sync = {s_q.sync[0], i_line};
    s_d.smp = {s_q.smp[0], s_q.sync[1]};
    // Majority of the newest three synchronised samples.
    vote = (s_q.sync[1] & s_q.smp[0]) | (s_q.sync[1] & s_q.smp[1])
         | (s_q.smp[0] & s_q.smp[1]);
    // The first tick after a change ends the window it fell in, so the
    // lock only lifts after a whole window has passed.
    if (s_q.lock == 2'h0 && vote != s_q.lvl) begin
      s_d.lvl = vote;
      s_d.rise = vote;
      s_d.fall = ~vote;
      s_d.lock = `CEC_REBOUND_TICKS;
    end else if (i_tick && s_q.lock != 2'h0) begin
      s_d.lock = s_q.lock - 2'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '{sync: 2'h3, smp: 2'h3, lvl: 1'b1, lock: 2'h0,
               rise: 1'b0, fall: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.lvl;
  assign o_rise = s_q.rise;
  assign o_fall = s_q.fall;

endmodule

// file: verilog/cec_ctrl.sv
`include "cec_consts.svh"

module cec_ctrl (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // Configuration
  input  wire logic [3:0]         i_own_addr,
  input  wire logic [13:0]        i_prescale_value,
  // Open-drain line
  input  wire logic               i_cec_i,
  output logic                    o_cec_o,
  output logic                    o_cec_oe,
  // Transmit bytes from the processor
  input  wire logic               i_tx_valid,
  input  wire cec_pkg::cec_byte_t i_tx,
  output logic                    o_tx_ready,
  // Received bytes to the processor
  output logic                    o_rx_valid,
  output cec_pkg::cec_byte_t      o_rx,
  // Event pulses
  output cec_pkg::cec_evt_t       o_evt
);

  ////////////////////////////////////////////////////////////////////////////

  cec_pkg::cec_ctrl_state_t s_q;
  cec_pkg::cec_ctrl_state_t s_d;

  logic       tick;
  logic       restart;
  logic       lvl;
  logic       rise;
  logic       fall;
  logic       lost;
  logic       begin_bit;
  logic       b;
  logic       ack_ok;
  logic [9:0] signal_free_time;
  logic [9:0] tot;

  function automatic logic in_rng(input logic [9:0] v,
                                  input logic [9:0] lo,
                                  input logic [9:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // Signal-free wait in quanta. A retry waits least and a follow-on
  // frame of our own longest, so others get a fair chance at the line.
  function automatic logic [9:0] sft_quanta(input logic retrying,
                                            input logic follow_on);
    if (retrying) begin
      return `CEC_LEAST_Q(`CEC_SFT_RETRY_BITS * `CEC_NOM_BIT_US);
    end else if (follow_on) begin
      return `CEC_LEAST_Q(`CEC_SFT_LAST_BITS * `CEC_NOM_BIT_US);
    end
    return `CEC_LEAST_Q(`CEC_SFT_NEW_BITS * `CEC_NOM_BIT_US);
  endfunction

  // Data low-time classes. Anything in neither window is a timing error.
  function automatic logic low_is_one(input logic [9:0] v);
    return in_rng(v, `CEC_LEAST_Q(`CEC_ONE_LOW_MIN_US),
                  `CEC_MOST_Q(`CEC_ONE_LOW_MAX_US));
  endfunction

  function automatic logic low_is_zero(input logic [9:0] v);
    return in_rng(v, `CEC_LEAST_Q(`CEC_ZERO_LOW_MIN_US),
                  `CEC_MOST_Q(`CEC_ZERO_LOW_MAX_US));
  endfunction

  // Next bit on the wire: payload MSB first, the end flag, then a
  // released acknowledge slot for the follower to pull down.
  function automatic logic bit_to_send(input logic [3:0] idx,
                                       input logic [7:0] sh,
                                       input logic       end_of_message_bit);
    if (idx < `CEC_EOM_IDX) begin
      return sh[3'(7 - idx)];
    end else if (idx == `CEC_EOM_IDX) begin
      return end_of_message_bit;
    end
    return 1'b1;
  endfunction

  cec_prescaler u_prescale_value (
    .i_clk            (i_clk),
    .i_rst            (i_rst),
    .i_prescale_value (i_prescale_value),
    .i_restart        (restart),
    .o_tick           (tick)
  );

  cec_rx_filter u_filt (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_line  (i_cec_i),
    .i_tick  (tick),
    .o_level (lvl),
    .o_rise  (rise),
    .o_fall  (fall)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_d = s_q;
    s_d.rx_valid = 1'b0;
    s_d.evt = '0;
    restart = 1'b0;
    lost = 1'b0;
    begin_bit = 1'b0;
    b = 1'b0;
    ack_ok = 1'b0;

    // Quantum timer, saturating so a long idle line reads as free.
    if (tick && s_q.t != `CEC_TIMER_MAX) begin
      s_d.t = s_q.t + 10'h1;
    end

    // The wait runs from the last falling edge seen, which is the start
    // of the final bit of the previous frame.
    signal_free_time = sft_quanta(s_q.retry != 3'h0, s_q.last_init);
    tot = s_q.start_ph ? `CEC_LEAST_Q(`CEC_TX_START_TOT_US)
                       : `CEC_LEAST_Q(`CEC_NOM_BIT_US);

    // One byte buffered at a time; the first byte of a message is the
    // header and gets our own address as its source nibble.
    if (i_tx_valid && !s_q.tx_full) begin
      s_d.tx_buf = i_tx;
      s_d.tx_full = 1'b1;
      if (!s_q.tx_pend) begin
        s_d.tx_pend = 1'b1;
        s_d.tx_buf.data[7:4] = i_own_addr;
      end
    end

    unique case (s_q.st)
      cec_pkg::ST_IDLE: begin
        if (fall) begin
          s_d.st = cec_pkg::ST_FRAME;
          s_d.start_ph = 1'b1;
          s_d.t = 10'h0;
          restart = 1'b1;
          s_d.idx = 4'h0;
          s_d.first = 1'b1;
          s_d.addr_me = 1'b0;
          s_d.bcast = 1'b0;
          s_d.low_len = `CEC_LEAST_Q(`CEC_TX_START_LOW_US);
        end else if (s_q.tx_pend && s_q.tx_full && !s_q.tx_act && lvl
                     && s_q.t >= signal_free_time) begin
          // Start bit; any other start seen together joins arbitration.
          s_d.drv = 1'b1;
          s_d.tx_act = 1'b1;
          s_d.tx_sh = s_q.tx_buf.data;
          s_d.tx_eom = s_q.tx_buf.end_of_message_bit;
          s_d.tx_bit = 1'b1;
          s_d.tx_full = 1'b0;
        end
      end

      cec_pkg::ST_FRAME: begin
        if (s_q.drv && s_q.t >= s_q.low_len && s_q.t < tot) begin
          s_d.drv = 1'b0;
        end else if (s_q.tx_act && !s_q.drv && lvl && s_q.t >= tot) begin
          s_d.drv = 1'b1;
        end

        if (fall) begin
          s_d.t = 10'h0;
          restart = 1'b1;
          if (s_q.start_ph) begin
            if (in_rng(s_q.t, `CEC_LEAST_Q(`CEC_START_TOT_MIN_US),
                       `CEC_MOST_Q(`CEC_START_TOT_MAX_US))) begin
              s_d.start_ph = 1'b0;
              begin_bit = 1'b1;
              if (!s_q.tx_act) begin
                s_d.last_init = 1'b0;
              end
            end else begin
              // A bad start is dropped silently.
              s_d.st = cec_pkg::ST_IDLE;
              s_d.drv = 1'b0;
              lost = s_q.tx_act;
            end
          end else if (!in_rng(s_q.t, `CEC_LEAST_Q(`CEC_DATA_TOT_MIN_US),
                              `CEC_MOST_Q(`CEC_DATA_TOT_MAX_US))) begin
            s_d.evt.bit_period_error = 1'b1;
            s_d.st = cec_pkg::ST_ERR;
            s_d.drv = 1'b1;
            lost = s_q.tx_act;
          end else begin
            begin_bit = 1'b1;
          end
        end else if (rise) begin
          if (s_q.start_ph) begin
            if (!in_rng(s_q.t, `CEC_LEAST_Q(`CEC_START_LOW_MIN_US),
                        `CEC_MOST_Q(`CEC_START_LOW_MAX_US))) begin
              s_d.st = cec_pkg::ST_IDLE;
              s_d.drv = 1'b0;
              lost = s_q.tx_act;
            end
          end else if (!low_is_one(s_q.t) && !low_is_zero(s_q.t)) begin
            // The period check of this bit never runs: timing wins.
            s_d.evt.bit_timing_error = 1'b1;
            s_d.st = cec_pkg::ST_ERR;
            s_d.drv = 1'b1;
            s_d.t = 10'h0;
            restart = 1'b1;
            lost = s_q.tx_act;
          end else begin
            b = low_is_one(s_q.t);
            if (s_q.tx_act && s_q.tx_bit && !b && s_q.idx != `CEC_ACK_IDX)
            begin
              if (s_q.first && s_q.idx <= `CEC_SRC_LAST_IDX) begin
                // Already released; drop out and follow the winner.
                s_d.tx_act = 1'b0;
                s_d.drv = 1'b0;
                s_d.evt.arb_lost = 1'b1;
              end else begin
                lost = 1'b1;
              end
            end
            if (s_q.idx < `CEC_EOM_IDX) begin
              s_d.sh = {s_q.sh[6:0], b};
              if (s_q.first && s_q.idx == `CEC_DST_LAST_IDX) begin
                s_d.addr_me = ({s_q.sh[2:0], b} == i_own_addr);
                s_d.bcast = ({s_q.sh[2:0], b} == `CEC_BCAST_ADDR);
              end
              s_d.idx = s_q.idx + 4'h1;
            end else if (s_q.idx == `CEC_EOM_IDX) begin
              s_d.end_of_message_bit = b;
              s_d.idx = s_q.idx + 4'h1;
            end else begin
              if (s_q.tx_act && !lost) begin
                ack_ok = s_q.bcast ? b : !b;
                if (!ack_ok) begin
                  lost = 1'b1;
                end else if (s_q.end_of_message_bit) begin
                  s_d.evt.tx_done = 1'b1;
                  s_d.tx_act = 1'b0;
                  s_d.tx_pend = 1'b0;
                  s_d.retry = 3'h0;
                  s_d.last_init = 1'b1;
                end else if (s_q.tx_full) begin
                  s_d.tx_sh = s_q.tx_buf.data;
                  s_d.tx_eom = s_q.tx_buf.end_of_message_bit;
                  s_d.tx_full = 1'b0;
                end else begin
                  lost = 1'b1;
                end
              end else if (!s_q.tx_act && (s_q.addr_me || s_q.bcast)) begin
                s_d.rx_valid = 1'b1;
                s_d.rx = '{data: s_q.sh, end_of_message_bit: s_q.end_of_message_bit};
              end
              s_d.idx = 4'h0;
              s_d.first = 1'b0;
              if (s_q.end_of_message_bit) begin
                // Bits after this need a fresh start bit, so any
                // trailing blocks are ignored.
                s_d.st = cec_pkg::ST_IDLE;
                s_d.tx_act = 1'b0;
              end
            end
          end
        end else if (s_q.t > `CEC_MOST_Q(`CEC_START_TOT_MAX_US)) begin
          // Frame stalled: the line stuck high or low too long.
          s_d.st = cec_pkg::ST_IDLE;
          s_d.drv = 1'b0;
          lost = s_q.tx_act;
        end

        // Our own bits are received as well, so a frame we send passes
        // through the same checks as one sent by anybody else.
        if (begin_bit) begin
          if (s_q.tx_act || (s_q.start_ph && s_d.tx_act)) begin
            s_d.tx_bit = bit_to_send(s_q.idx, s_q.tx_sh, s_q.tx_eom);
            s_d.low_len = s_d.tx_bit ? `CEC_LEAST_Q(`CEC_TX_ONE_LOW_US)
                                     : `CEC_LEAST_Q(`CEC_TX_ZERO_LOW_US);
          end else if (s_q.idx == `CEC_ACK_IDX && s_q.addr_me) begin
            // As the addressed follower we acknowledge with a zero.
            s_d.drv = 1'b1;
            s_d.low_len = `CEC_LEAST_Q(`CEC_TX_ZERO_LOW_US);
          end
        end
      end

      // Error bit: hold the line low for the nominal length, then go
      // idle with the timer already counting signal-free time.
      cec_pkg::ST_ERR: begin
        if (s_q.t >= `CEC_LEAST_Q(`CEC_ERR_LOW_US)) begin
          s_d.drv = 1'b0;
          s_d.st = cec_pkg::ST_IDLE;
        end
      end
    endcase

    // The error bit is timed from its own first edge, whichever check
    // raised it.
    if (s_d.st == cec_pkg::ST_ERR && s_q.st != cec_pkg::ST_ERR) begin
      s_d.t = 10'h0;
      restart = 1'b1;
    end

    // A lost message is offered again until the retry budget runs out;
    // the processor resupplies it from the header on each retry pulse.
    if (lost) begin
      s_d.tx_act = 1'b0;
      s_d.tx_full = 1'b0;
      if (s_q.st != cec_pkg::ST_ERR && s_d.st != cec_pkg::ST_ERR) begin
        s_d.drv = 1'b0;
      end
      if (s_q.retry < `CEC_MAX_RETRY) begin
        s_d.retry = s_q.retry + 3'h1;
        s_d.evt.tx_retry = 1'b1;
        s_d.tx_pend = 1'b0;
      end else begin
        s_d.retry = 3'h0;
        s_d.evt.tx_fail = 1'b1;
        s_d.tx_pend = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.st <= cec_pkg::ST_IDLE;
      s_q.t <= `CEC_TIMER_MAX;
    end else begin
      s_q <= s_d;
    end
  end

  // Never drive high: the pull-up makes the one level.
  assign o_cec_o = 1'b0;
  assign o_cec_oe = s_q.drv;
  assign o_tx_ready = ~s_q.tx_full;
  assign o_rx_valid = s_q.rx_valid;
  assign o_rx = s_q.rx;
  assign o_evt = s_q.evt;

endmodule

// file: sim/cec_ctrl_props.sv
module cec_ctrl_props (
  // Clock and reset
  input wire logic               i_clk,
  input wire logic               i_rst,
  // Configuration and line
  input wire logic [3:0]         i_own_addr,
  input wire logic [13:0]        i_prescale_value,
  input wire logic               i_cec_i,
  input wire logic               o_cec_o,
  input wire logic               o_cec_oe,
  // Byte streams and events
  input wire logic               i_tx_valid,
  input wire cec_pkg::cec_byte_t i_tx,
  input wire logic               o_tx_ready,
  input wire logic               o_rx_valid,
  input wire cec_pkg::cec_byte_t o_rx,
  input wire cec_pkg::cec_evt_t  o_evt
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  int          q;
  logic        line_q;
  logic [15:0] since_fall;
  logic [15:0] oe_run;

  assign q = int'(i_prescale_value) + 1;

  ////////////////////////////////////////////////////////////
  // Reset leaves the line idle for long, so the first launch is legal.
  always_ff @(posedge i_clk) begin
    line_q <= i_cec_i;
    if (i_rst) since_fall <= 16'hffff;
    else if (line_q && !i_cec_i) since_fall <= 16'h0000;
    else if (since_fall != 16'hffff) since_fall <= since_fall + 16'h0001;
    if (i_rst || !o_cec_oe) oe_run <= 16'h0000;
    else oe_run <= oe_run + 16'h0001;
  end

  ////////////////////////////////////////////////////////////
  property p_open_drain; o_cec_oe |-> !o_cec_o; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("line driven high");
  property p_reset_quiet;
    $fell(i_rst) |-> !o_cec_oe && o_tx_ready && !o_rx_valid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs busy after reset");
  property p_take_byte; i_tx_valid && o_tx_ready |=> !o_tx_ready; endproperty
  a_take_byte: assert property (p_take_byte)
    else $error("byte not taken");
  property p_rx_pulse; o_rx_valid |=> !o_rx_valid; endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("receive strobe too long");
  property p_rx_at_high; o_rx_valid |-> i_cec_i; endproperty
  a_rx_at_high: assert property (p_rx_at_high)
    else $error("byte delivered while line low");
  property p_one_error; !(o_evt.bit_timing_error && o_evt.bit_period_error); endproperty
  a_one_error: assert property (p_one_error)
    else $error("both receive errors reported");
  property p_err_bit; o_evt.bit_timing_error || o_evt.bit_period_error |-> ##[0:4] o_cec_oe; endproperty
  a_err_bit: assert property (p_err_bit)
    else $error("no error bit driven");
  property p_sft;
    $rose(o_cec_oe) && since_fall > 100 * q |-> since_fall >= 144 * q;
  endproperty
  a_sft: assert property (p_sft)
    else $error("frame launched too early");
  property p_oe_bound; o_cec_oe |-> oe_run < 78 * q; endproperty
  a_oe_bound: assert property (p_oe_bound)
    else $error("line held low too long");
  property p_arb_release;
    o_evt.arb_lost |-> ##[0:1] !o_cec_oe [*8];
  endproperty
  a_arb_release: assert property (p_arb_release)
    else $error("line still driven after lost arbitration");
  property p_done_high; o_evt.tx_done |-> i_cec_i; endproperty
  a_done_high: assert property (p_done_high)
    else $error("done while line low");
endmodule

// file: sim/cec_far_end.sv
module cec_far_end #(
  parameter int         Q       = 10,
  parameter logic [3:0] MY_ADDR = 4'h5
) (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_pull_low
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       tx_low    = 1'b0;
  logic       busy      = 1'b0;
  logic       prev      = 1'b1;
  logic       first     = 1'b0;
  logic       addressed = 1'b0;
  logic       last_eom  = 1'b0;
  logic [7:0] sh        = 8'h00;
  int         idx       = 0;
  int         lowc      = 0;
  int         ackc      = 0;
  logic [7:0] got[$];

  // Only ever pulls low; the pull-up restores the line on release.
  assign o_pull_low = tx_low || ackc != 0;

  ////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    prev <= i_line;
    if (ackc > 0) ackc <= ackc - 1;
    if (prev && !i_line) begin
      lowc <= 0;
      if (idx == 9 && addressed && !busy) ackc <= 30 * Q;
    end else if (!i_line) lowc <= lowc + 1;
    if (!prev && i_line) begin
      if (lowc > 60 * Q) begin
        idx <= 0;
        first <= 1'b1;
        addressed <= 1'b0;
      end else begin
        if (idx < 8) sh <= {sh[6:0], lowc < 20 * Q};
        if (idx == 8) begin
          last_eom <= lowc < 20 * Q;
          got.push_back(sh);
          if (first) addressed <= sh[3:0] == MY_ADDR;
          first <= 1'b0;
        end
        idx <= (idx == 9) ? 0 : idx + 1;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic pulse(input int low_q, input int tot_q);
    @(posedge i_clk) #1 tx_low = 1'b1;
    repeat (low_q * Q) @(posedge i_clk);
    #1 tx_low = 1'b0;
    repeat ((tot_q - low_q) * Q - 1) @(posedge i_clk);
  endtask

  task automatic send_byte(input logic [7:0] d, input logic e,
                           output logic acked);
    busy = 1'b1;
    for (int i = 7; i >= 0; i--) pulse(d[i] ? 12 : 30, 48);
    pulse(e ? 12 : 30, 48);
    pulse(12, 24);
    acked = !i_line;
    repeat (24 * Q) @(posedge i_clk);
    busy = 1'b0;
  endtask
endmodule

// file: sim/cec_ctrl_tb.sv
module cec_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int Q = 10;

  logic               i_clk    = 1'b0;
  logic               i_rst    = 1'b1;
  logic               tx_valid = 1'b0;
  cec_pkg::cec_byte_t tx       = '0;
  wire logic          cec_line;
  logic               oe, cec_o, tx_ready, rx_valid, far_low;
  cec_pkg::cec_byte_t rx;
  cec_pkg::cec_evt_t  evt;
  logic [5:0]         seen     = '0;
  cec_pkg::cec_byte_t rxq[$];
  int                 run      = 0;
  int                 oe_len   = 0;
  int                 bad_count = 0;
  int                 samples_checked = 0;

  always #20 i_clk = ~i_clk;
  assign cec_line = (oe ? cec_o : 1'b1) & !far_low;

  cec_ctrl DUT (.i_clk(i_clk), .i_rst(i_rst), .i_own_addr(4'h2),
    .i_prescale_value(14'h0009), .i_cec_i(cec_line), .o_cec_o(cec_o),
    .o_cec_oe(oe), .i_tx_valid(tx_valid), .i_tx(tx),
    .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx(rx), .o_evt(evt));
  cec_far_end #(.Q(Q), .MY_ADDR(4'h5)) far (.i_clk(i_clk),
    .i_line(cec_line), .o_pull_low(far_low));

  ////////////////////////////////////////////////////////////
  // Events are single-cycle pulses, so they are latched for the tasks.
  always @(posedge i_clk) begin
    seen <= seen | evt;
    if (rx_valid) rxq.push_back(rx);
    if (oe) run <= run + 1;
    else if (run != 0) begin
      oe_len <= run;
      run <= 0;
    end
  end

  task automatic chk(input logic bad, input string m);
    samples_checked++;
    if (bad !== 1'b0) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wait_evt(input logic [5:0] m, input int lim);
    for (int n = 0; n < lim && (seen & m) == '0; n++) wait_cyc(1);
  endtask

  // The offer is raised only while ready stands, so one edge takes it.
  task automatic put(input logic [7:0] d, input logic e);
    wait_cyc(1);
    for (int n = 0; n < 20000 && tx_ready !== 1'b1; n++) wait_cyc(1);
    tx_valid = 1'b1;
    tx = {d, e};
    @(posedge i_clk) #1 tx_valid = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_ping;
    seen = '0;
    put(8'h05, 1'b1);
    wait_evt(6'h04, 12000);
    chk(seen[2] !== 1'b1, "ping not completed");
    chk(far.got[far.got.size() - 1] !== 8'h25, "header wrong");
    chk(far.last_eom !== 1'b1, "ping lacks end flag");
    $display("test ping done");
  endtask

  task automatic t_two;
    seen = '0;
    far.got.delete();
    put(8'h05, 1'b0);
    put(8'h3c, 1'b1);
    wait_evt(6'h04, 15000);
    chk(seen[2] !== 1'b1, "message not completed");
    chk(far.got.size() != 2, "block count wrong");
    chk(far.got[1] !== 8'h3c, "opcode wrong");
    $display("test two blocks done");
  endtask

  task automatic t_rx;
    logic ack;
    rxq.delete();
    wait_cyc(150 * Q);
    far.pulse(74, 90);
    far.send_byte(8'h52, 1'b0, ack);
    chk(ack !== 1'b1, "header not acknowledged");
    far.send_byte(8'ha5, 1'b1, ack);
    wait_cyc(5);
    chk(rxq.size() != 2, "byte count wrong");
    chk(rxq[0] !== {8'h52, 1'b0}, "header byte wrong");
    chk(rxq[1] !== {8'ha5, 1'b1}, "last byte wrong");
    $display("test receive done");
  endtask

  task automatic t_bte;
    seen = '0;
    wait_cyc(150 * Q);
    far.pulse(74, 90);
    far.pulse(20, 48);
    wait_cyc(100 * Q);
    chk(seen[5:4] !== 2'b10, "timing error not flagged");
    chk(oe_len < 67 * Q || oe_len > 77 * Q, "error bit length");
    $display("test timing error done");
  endtask

  task automatic t_bpe;
    seen = '0;
    wait_cyc(150 * Q);
    far.pulse(74, 90);
    far.pulse(12, 60);
    far.pulse(12, 48);
    wait_cyc(100 * Q);
    chk(seen[5:4] !== 2'b01, "period error not flagged");
    $display("test period error done");
  endtask

  task automatic t_retry;
    for (int k = 0; k < 6; k++) begin
      seen = '0;
      put(8'h07, 1'b1);
      wait_evt(6'h03, 12000);
      chk(seen[0] !== (k == 5), "give-up count wrong");
      if (k < 5) chk(seen[1] !== 1'b1, "no retry on missing ack");
    end
    $display("test retry done");
  endtask

  task automatic t_arb;
    logic ack;
    seen = '0;
    rxq.delete();
    put(8'h05, 1'b1);
    for (int n = 0; n < 20000 && oe !== 1'b1; n++) wait_cyc(1);
    far.pulse(74, 90);
    far.send_byte(8'h02, 1'b1, ack);
    wait_cyc(10);
    chk(seen[3] !== 1'b1, "arbitration loss not seen");
    chk(ack !== 1'b1, "winner not acknowledged");
    chk(rxq[0] !== {8'h02, 1'b1}, "winner byte lost");
    $display("test arbitration done");
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_clk);
    #1 i_rst = 1'b0;
    t_ping;
    t_two;
    t_rx;
    t_bte;
    t_bpe;
    t_retry;
    t_arb;
    stop_test;
  end

  initial begin
    repeat (98000) @(posedge i_clk);
    bad_count++;
    stop_test;
  end
endmodule

bind cec_ctrl cec_ctrl_props u_props (.i_clk, .i_rst, .i_own_addr,
  .i_prescale_value, .i_cec_i, .o_cec_o, .o_cec_oe, .i_tx_valid, .i_tx,
  .o_tx_ready, .o_rx_valid, .o_rx, .o_evt);
